//--- cmie_pkg.sv
package cmie_pkg;

    // ****************************************************************
    // Instruction encodings (12-bit words)
    // ****************************************************************
    localparam logic [11:0] OPC_OPTION_LOAD = 12'h002;
    localparam logic [11:0] OPC_SLEEP = 12'h003;
    localparam logic [3:0] OPC_RETLIT_HI = 4'h8;
    localparam logic [5:0] OPC_ROT_LEFT_HI = 6'h0d;
    localparam logic [5:0] OPC_ROT_RIGHT_HI = 6'h0c;
    localparam int DEST_BIT = 5;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_WREG = 8'h04;
    localparam logic [7:0] ADDR_OPTION = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_PC = 8'h10;
    localparam logic [7:0] ADDR_STACK = 8'h14;
    localparam logic [7:0] ADDR_WAKE = 8'h18;
    localparam logic [7:0] ADDR_FILE = 8'h80;
    localparam int FILE_WORDS = 32;

    // ****************************************************************
    // Status bit positions and reset values
    // ****************************************************************
    localparam int ST_CARRY = 0;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] OPTION_RST = 8'hff;
    localparam logic [7:0] WDT_CLEAR = 8'h00;
    localparam int STACK_DEPTH = 4;

    typedef enum logic [1:0] {
        CMIE_READY,
        CMIE_FLUSH,
        CMIE_ASLEEP
    } cmie_state_t;

endpackage

//--- cmie_file_if.sv
interface cmie_file_if;
    import cmie_pkg::*;
    logic [4:0] raddr;
    logic [7:0] rdata;
    logic we;
    logic [4:0] waddr;
    logic [7:0] wdata;
    modport core (output raddr, input rdata, output we, output waddr, output wdata);
    modport mem (input raddr, output rdata, input we, input waddr, input wdata);
endinterface

//--- cmie_file_regs.sv
module cmie_file_regs
    import cmie_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    cmie_file_if.mem fp
);

    logic [7:0] mem_q [FILE_WORDS];

    assign fp.rdata = mem_q[fp.raddr];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < FILE_WORDS; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (fp.we) begin
            mem_q[fp.waddr] <= fp.wdata;
        end
    end

endmodule

//--- cmie_top.sv
// How it works
// - Option-load copies the accumulator into the option register, flags untouched.
// - Literal-return puts the 8-bit literal in the accumulator, flags untouched.
// - Literal-return pops the stack and loads the program counter from it.
// - Literal-return takes two cycles; the second executes nothing.
// - Left rotate through carry: old carry into bit 0, bit 7 to carry.
// - Right rotate through carry: old carry into bit 7, bit 0 to carry.
// - Destination bit 0 sends result to accumulator, 1 back to file register.
// - Sleep clears the watchdog counter and its prescaler in one cycle.
// - Sleep sets time-out flag, clears power-down flag, nothing else.
module cmie_top
    import cmie_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic WAKE_UP,
    output logic OSC_RUN,
    output logic WATCHDOG_CLEAR
);

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic aw_q, w_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q, rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q, bresp_q;
    logic wr_go;
    logic [7:0] rd_addr;

    assign S_AXI_AWREADY = !aw_q && !bvalid_q;
    assign S_AXI_WREADY = !w_q && !bvalid_q;
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    assign wr_go = aw_q && w_q && !bvalid_q;
    assign rd_addr = S_AXI_ARADDR[7:0];

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR[7:0];
            end else if (wr_go) begin
                aw_q <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_q <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end else if (wr_go) begin
                w_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Core state
    // ****************************************************************
    cmie_state_t state_q;
    logic [7:0] w_reg_q, option_q, status_q, prescale_q, wdt_q;
    logic [8:0] pc_q;
    logic [8:0] stack_q [STACK_DEPTH];
    logic [1:0] sp_q;
    logic [11:0] instr;
    logic exec;
    logic is_option, is_sleep, is_retlit, is_rotl, is_rotr, is_rot;
    logic [7:0] rot_res;
    logic rot_carry;
    logic [1:0] sp_pop;
    logic bus_wr_file, bus_wr_stack;
    cmie_file_if fbus ();

    cmie_file_regs u_file (
        .clk(CLK),
        .arst_n(ARST_N),
        .fp(fbus)
    );

    // Software issues an instruction by writing its word to ADDR_INSTR.
    assign instr = wdata_q[11:0];
    assign exec = wr_go && (awaddr_q == ADDR_INSTR) && (state_q == CMIE_READY);
    assign is_option = (instr == OPC_OPTION_LOAD);
    assign is_sleep = (instr == OPC_SLEEP);
    assign is_retlit = (instr[11:8] == OPC_RETLIT_HI);
    assign is_rotl = (instr[11:6] == OPC_ROT_LEFT_HI);
    assign is_rotr = (instr[11:6] == OPC_ROT_RIGHT_HI);
    assign is_rot = is_rotl || is_rotr;
    assign sp_pop = sp_q - 2'd1;
    // The file window ends at the top of the byte space, so its bound needs a ninth bit.
    assign bus_wr_file = wr_go && (awaddr_q >= ADDR_FILE) && (awaddr_q[1:0] == 2'b00)
        && ({1'b0, awaddr_q} < 9'(ADDR_FILE + 4 * FILE_WORDS)) && wstrb_q[0];
    assign bus_wr_stack = wr_go && (awaddr_q == ADDR_STACK) && wstrb_q[0] && wstrb_q[1];

    always_comb begin
        if (is_rotl) begin
            rot_res = {fbus.rdata[6:0], status_q[ST_CARRY]};
            rot_carry = fbus.rdata[7];
        end else begin
            rot_res = {status_q[ST_CARRY], fbus.rdata[7:1]};
            rot_carry = fbus.rdata[0];
        end
    end

    // The file port is shared; during an executed rotate the bus write path is unused.
    assign fbus.raddr = instr[4:0];
    assign fbus.we = (exec && is_rot && instr[DEST_BIT]) || bus_wr_file;
    assign fbus.waddr = exec ? instr[4:0] : awaddr_q[6:2];
    assign fbus.wdata = exec ? rot_res : wdata_q[7:0];

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= CMIE_READY;
        end else begin
            case (state_q)
                CMIE_READY: begin
                    if (exec && is_retlit) begin
                        state_q <= CMIE_FLUSH;
                    end else if (exec && is_sleep) begin
                        state_q <= CMIE_ASLEEP;
                    end
                end
                CMIE_FLUSH: state_q <= CMIE_READY;
                CMIE_ASLEEP: begin
                    if (WAKE_UP) begin
                        state_q <= CMIE_READY;
                    end
                end
                default: state_q <= CMIE_READY;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            w_reg_q <= 8'h00;
        end else if (exec && is_retlit) begin
            w_reg_q <= instr[7:0];
        end else if (exec && is_rot && !instr[DEST_BIT]) begin
            w_reg_q <= rot_res;
        end else if (wr_go && awaddr_q == ADDR_WREG && wstrb_q[0]) begin
            w_reg_q <= wdata_q[7:0];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            option_q <= OPTION_RST;
        end else if (exec && is_option) begin
            option_q <= w_reg_q;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            status_q <= STATUS_RST;
        end else if (exec && is_rot) begin
            status_q[ST_CARRY] <= rot_carry;
        end else if (exec && is_sleep) begin
            status_q[ST_TO] <= 1'b1;
            status_q[ST_PD] <= 1'b0;
        end else if (wr_go && awaddr_q == ADDR_STATUS && wstrb_q[0]) begin
            status_q <= wdata_q[7:0];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wdt_q <= WDT_CLEAR;
            prescale_q <= WDT_CLEAR;
        end else if (exec && is_sleep) begin
            wdt_q <= WDT_CLEAR;
            prescale_q <= WDT_CLEAR;
        end else if (state_q != CMIE_ASLEEP) begin
            prescale_q <= prescale_q + 8'h01;
            if (prescale_q == 8'hff) begin
                wdt_q <= wdt_q + 8'h01;
            end
        end
    end

    assign WATCHDOG_CLEAR = exec && is_sleep;
    assign OSC_RUN = (state_q != CMIE_ASLEEP);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pc_q <= 9'h000;
            sp_q <= 2'd0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= 9'h000;
            end
        end else if (exec && is_retlit) begin
            pc_q <= stack_q[sp_pop];
            sp_q <= sp_pop;
        end else if (exec) begin
            pc_q <= pc_q + 9'h001;
        end else if (bus_wr_stack) begin
            stack_q[sp_q] <= wdata_q[8:0];
            sp_q <= sp_q + 2'd1;
        end else if (wr_go && awaddr_q == ADDR_PC && wstrb_q[0] && wstrb_q[1]) begin
            pc_q <= wdata_q[8:0];
        end
    end

    // ****************************************************************
    // Responses
    // ****************************************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= (awaddr_q == ADDR_INSTR || awaddr_q == ADDR_WREG
                || awaddr_q == ADDR_STATUS || awaddr_q == ADDR_PC
                || awaddr_q == ADDR_STACK || bus_wr_file
                || (awaddr_q >= ADDR_FILE && awaddr_q[1:0] == 2'b00)) ? 2'b00 : 2'b10;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'b00;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_q <= 1'b1;
            rresp_q <= 2'b00;
            case (rd_addr)
                ADDR_INSTR: rdata_q <= {30'h0, state_q};
                ADDR_WREG: rdata_q <= {24'h0, w_reg_q};
                ADDR_OPTION: rdata_q <= {24'h0, option_q};
                ADDR_STATUS: rdata_q <= {24'h0, status_q};
                ADDR_PC: rdata_q <= {23'h0, pc_q};
                ADDR_STACK: rdata_q <= {22'h0, sp_q, 8'h00};
                ADDR_WAKE: rdata_q <= {16'h0, prescale_q, wdt_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= 2'b10;
                end
            endcase
        end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

//--- cmie_monitor.sv
module cmie_monitor
    import cmie_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic WAKE_UP,
    input wire logic OSC_RUN,
    input wire logic WATCHDOG_CLEAR
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    sequence s_wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    // Only a sleep taken while running counts, since a sleeping core ignores instructions.
    sequence s_sleep_taken;
        s_wr_taken ##0 (S_AXI_AWADDR[7:0] == ADDR_INSTR && S_AXI_WDATA[11:0] == OPC_SLEEP
            && OSC_RUN);
    endsequence

    // The core executes one cycle after both write channels are taken.
    a_sleep_clears: assert property (s_sleep_taken |=> WATCHDOG_CLEAR)
        else $error("no watchdog clear on sleep");
    a_clear_cause: assert property (WATCHDOG_CLEAR |=> S_AXI_BVALID)
        else $error("watchdog clear without a write");
    a_sleep_halts: assert property (s_sleep_taken |-> ##2 !OSC_RUN)
        else $error("oscillator still running after sleep");
    a_asleep_holds: assert property (!OSC_RUN && !WAKE_UP |=> !OSC_RUN)
        else $error("left sleep without wake-up");
    a_wake_resumes: assert property (!OSC_RUN && WAKE_UP |-> ##[1:2] OSC_RUN)
        else $error("wake-up did not restart oscillator");
    a_asleep_quiet: assert property (!OSC_RUN |-> !WATCHDOG_CLEAR)
        else $error("instruction executed while asleep");
    a_write_answered: assert property (s_wr_taken |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    a_read_answered: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read response late");
endmodule

bind cmie_top cmie_monitor u_mon (.CLK(CLK), .ARST_N(ARST_N), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .WAKE_UP(WAKE_UP), .OSC_RUN(OSC_RUN),
    .WATCHDOG_CLEAR(WATCHDOG_CLEAR));

//--- testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import cmie_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic awv = 1'b0, wv = 1'b0, arv = 1'b0, wake = 1'b0;
    logic [31:0] awa = '0, wd = '0, ara = '0, rdat, rd_q;
    logic [1:0] bresp, rresp, bres, rres;
    logic awr, wrdy, bv, arr, rv, osc, wdc;
    int num_errors = 0, n_compared = 0, ncyc = 0;

    cmie_top dut (.CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1), .WAKE_UP(wake),
        .OSC_RUN(osc), .WATCHDOG_CLEAR(wdc));

    initial forever #2.5 clk = ~clk;

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Both ready lines may come in either order, so each channel drops on its own.
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awa <= {24'h0, a};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (aw || w) begin
            @(posedge clk);
            if (awr === 1'b1) aw = 1'b0;
            if (wrdy === 1'b1) w = 1'b0;
            awv <= aw;
            wv <= w;
        end
        do @(posedge clk); while (bv !== 1'b1);
        bres = bresp;
    endtask

    task automatic rd(logic [7:0] a);
        ara <= {24'h0, a};
        arv <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rd_q = rdat;
        rres = rresp;
    endtask

    task automatic rc(string nm, logic [7:0] a, logic [31:0] e);
        rd(a);
        chk(nm, e, rd_q);
    endtask

    task automatic exec(logic [11:0] i);
        wr(ADDR_INSTR, {20'h0, i});
    endtask

    function automatic logic [8:0] rot(logic l, logic [7:0] v, logic c);
        return l ? {v, c} : {v[0], c, v[7:1]};
    endfunction

    task automatic t_reset();
        rc("state", ADDR_INSTR, 32'h0);
        rc("w", ADDR_WREG, 32'h0);
        rc("option", ADDR_OPTION, {24'h0, OPTION_RST});
        rc("status", ADDR_STATUS, {24'h0, STATUS_RST});
        rd(8'h40);
        chk("rresp", 32'h2, {30'h0, rres});
        chk("rdata", 32'h0, rd_q);
        wr(8'h44, 32'h1);
        chk("bresp", 32'h2, {30'h0, bres});
    endtask

    task automatic t_option();
        wr(ADDR_WREG, 32'h5a);
        wr(ADDR_STATUS, 32'h19);
        exec(OPC_OPTION_LOAD);
        rc("option", ADDR_OPTION, 32'h5a);
        wr(ADDR_WREG, 32'ha5);
        exec(OPC_OPTION_LOAD);
        rc("option", ADDR_OPTION, 32'ha5);
        rc("status", ADDR_STATUS, 32'h19);
    endtask

    task automatic t_return_with_literal();
        wr(ADDR_STACK, 32'h123);
        // A read issued two edges after the call is taken in the cycle after execution.
        fork
            exec({OPC_RETLIT_HI, 8'hc3});
            begin
                repeat (2) @(posedge clk);
                rc("flush", ADDR_INSTR, 32'h1);
            end
        join
        rc("w", ADDR_WREG, 32'hc3);
        rc("pc", ADDR_PC, 32'h123);
        rc("status", ADDR_STATUS, 32'h19);
        rc("state", ADDR_INSTR, 32'h0);
    endtask

    task automatic t_rot();
        logic [8:0] e;
        logic [4:0] f;
        logic [5:0] op;
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            f = {5{i[0]}};
            v = 8'he6 ^ 8'(i);
            op = i[1] ? OPC_ROT_LEFT_HI : OPC_ROT_RIGHT_HI;
            e = rot(i[1], v, i[0] ^ i[1]);
            wr(ADDR_FILE + {1'b0, f, 2'b00}, {24'h0, v});
            wr(ADDR_STATUS, {24'h0, STATUS_RST} | (i[0] ^ i[1]));
            wr(ADDR_WREG, 32'h3c);
            exec({op, i[0], f});
            rc("carry", ADDR_STATUS, {24'h0, STATUS_RST} | e[8]);
            if (i[0]) begin
                rc("w kept", ADDR_WREG, 32'h3c);
                exec({op, 1'b0, f});
                e = rot(i[1], e[7:0], e[8]);
            end
            rc("result", ADDR_WREG, {24'h0, e[7:0]});
        end
    endtask

    task automatic t_sleep();
        int n;
        wr(ADDR_STATUS, 32'h09);
        repeat (20) @(posedge clk);
        exec(OPC_SLEEP);
        chk("osc", 32'h0, {31'h0, osc});
        rc("status", ADDR_STATUS, 32'h11);
        rc("watchdog", ADDR_WAKE, 32'h0);
        rc("state", ADDR_INSTR, 32'h2);
        exec(OPC_OPTION_LOAD);
        chk("bresp asleep", 32'h0, {30'h0, bres});
        exec(OPC_SLEEP);
        rc("state", ADDR_INSTR, 32'h2);
        wake <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (osc !== 1'b1 && n < 8);
        wake <= 1'b0;
        chk("osc awake", 32'h1, {31'h0, osc});
        rc("state", ADDR_INSTR, 32'h0);
        rc("option", ADDR_OPTION, 32'ha5);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_option();
        t_return_with_literal();
        t_rot();
        t_sleep();
        stop_test();
    end

    always @(posedge clk) begin
        ncyc++;
        if (ncyc == 5000) begin
            num_errors++;
            stop_test();
        end
    end
endmodule
